// *** design/gmx_pkg.sv ***
/*
  Package for the pin multiplexer and general-purpose port block: register
  word offsets, field layout, mode codes, reset values and the carrier and
  state types.
  Assumes a 16-bit word-addressed peripheral frame, 36 pin positions of which
  34 are bonded out, and a single core clock.
*/
package gmx_pkg;

  // pin counts and structure
  localparam int GMX_NPIN = 36;
  localparam int GMX_NPIN_A = 32;
  localparam int GMX_NPIN_B = 4;
  localparam int GMX_NSRC = 3;
  localparam int GMX_QHIST = 6;
  localparam int GMX_NGRP = 5;
  localparam int GMX_GRP_PINS = 8;
  localparam int GMX_SEL_W = 5;
  localparam int GMX_CNT_W = 9;

  // register word offsets; each two-word register starts on an even word
  localparam logic [15:0] GMX_OFS_CTRL_A = 16'h6F80;
  localparam logic [15:0] GMX_OFS_QSEL_A_LO = 16'h6F82;
  localparam logic [15:0] GMX_OFS_QSEL_A_HI = 16'h6F84;
  localparam logic [15:0] GMX_OFS_MUX_A_LO = 16'h6F86;
  localparam logic [15:0] GMX_OFS_MUX_A_HI = 16'h6F88;
  localparam logic [15:0] GMX_OFS_DIR_A = 16'h6F8A;
  localparam logic [15:0] GMX_OFS_PUD_A = 16'h6F8C;
  localparam logic [15:0] GMX_OFS_CTRL_B = 16'h6F90;
  localparam logic [15:0] GMX_OFS_QSEL_B_LO = 16'h6F92;
  localparam logic [15:0] GMX_OFS_QSEL_B_HI = 16'h6F94;
  localparam logic [15:0] GMX_OFS_MUX_B_LO = 16'h6F96;
  localparam logic [15:0] GMX_OFS_MUX_B_HI = 16'h6F98;
  localparam logic [15:0] GMX_OFS_DIR_B = 16'h6F9A;
  localparam logic [15:0] GMX_OFS_PUD_B = 16'h6F9C;
  localparam logic [15:0] GMX_OFS_DAT_A = 16'h6FC0;
  localparam logic [15:0] GMX_OFS_SET_A = 16'h6FC2;
  localparam logic [15:0] GMX_OFS_CLR_A = 16'h6FC4;
  localparam logic [15:0] GMX_OFS_TGL_A = 16'h6FC6;
  localparam logic [15:0] GMX_OFS_DAT_B = 16'h6FC8;
  localparam logic [15:0] GMX_OFS_SET_B = 16'h6FCA;
  localparam logic [15:0] GMX_OFS_CLR_B = 16'h6FCC;
  localparam logic [15:0] GMX_OFS_TGL_B = 16'h6FCE;
  localparam logic [15:0] GMX_OFS_EXTERNAL_INTERRUPT_ONE_SEL = 16'h6FE0;
  localparam logic [15:0] GMX_OFS_EXTERNAL_INTERRUPT_TWO_SEL = 16'h6FE1;
  localparam logic [15:0] GMX_OFS_NMI_SEL = 16'h6FE2;
  localparam logic [15:0] GMX_OFS_WAKE_SEL = 16'h6FE8;

  // pin select field codes
  localparam logic [1:0] GMX_MUX_IO = 2'h0;

  // input qualification codes
  localparam logic [1:0] GMX_Q_SYNC = 2'h0;
  localparam logic [1:0] GMX_Q_3SMP = 2'h1;
  localparam logic [1:0] GMX_Q_6SMP = 2'h2;
  localparam logic [1:0] GMX_Q_PASS = 2'h3;

  // reset values
  localparam logic [31:0] GMX_RST_W32 = 32'h0000_0000;
  localparam logic [7:0] GMX_RST_CTRL_B = 8'h00;
  localparam logic [35:0] GMX_RST_PIN = 36'h0_0000_0000;
  localparam logic [71:0] GMX_RST_FLD = 72'h00_0000_0000_0000_0000;
  localparam logic [4:0] GMX_RST_SEL = 5'h00;

  typedef struct packed {
    logic wr;
    logic rd;
    logic wide;
    logic [15:0] addr;
    logic [31:0] wdata;
  } gmx_bus_req_type;

  typedef struct packed {
    logic [GMX_NPIN-1:0] level;
    logic [GMX_NPIN-1:0] drive;
    logic [GMX_NPIN-1:0] pull_en;
  } gmx_pad_type;

  typedef struct packed {
    logic [GMX_NPIN-1:0] sync1;
    logic [GMX_NPIN-1:0] sync2;
    logic [GMX_NPIN-1:0][GMX_QHIST-1:0] hist;
    logic [GMX_NPIN-1:0] qual;
    logic [GMX_NGRP-1:0][GMX_CNT_W-1:0] cnt;
    logic [31:0] ctrl_a;
    logic [7:0] ctrl_b;
    logic [71:0] qsel;
    logic [71:0] mux;
    logic [GMX_NPIN-1:0] dir;
    logic [GMX_NPIN-1:0] pud;
    logic [GMX_NPIN-1:0] dat;
    logic [GMX_SEL_W-1:0] external_interrupt_one_sel;
    logic [GMX_SEL_W-1:0] external_interrupt_two_sel;
    logic [GMX_SEL_W-1:0] nmi_sel;
    logic [31:0] wake_sel;
    logic [2:0] irq_lvl;
    logic wake;
    logic [31:0] rdata;
    logic rvalid;
  } gmx_state_type;

endpackage

// *** design/gmx_port.sv ***
/*
  Pin multiplexer and general-purpose port: 36 pin positions (port A pins
  0..31, port B pins 32..35), per-pin choice of software I/O or one of three
  peripheral signals, direction, pull-up disable, input qualification, data
  set/clear/toggle, interrupt source and wake selection.
  Assumes a CPU on the same clock presenting word-addressed 16-bit or 32-bit
  accesses for one cycle, and pad inputs asynchronous to the core clock.
*/
module gmx_port
  import gmx_pkg::*;
(
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rstn_i,
  // cpu register port
  input wire gmx_bus_req_type bus_req_i,
  input wire logic protected_write_enable_i,
  output logic [31:0] bus_rdata_o,
  output logic bus_rvalid_o,
  // pads
  input wire logic [GMX_NPIN-1:0] pad_in_i,
  output gmx_pad_type pad_o,
  // peripheral side
  input wire logic [GMX_NSRC-1:0][GMX_NPIN-1:0] periph_out_i,
  input wire logic [GMX_NSRC-1:0][GMX_NPIN-1:0] periph_oe_i,
  output logic [GMX_NPIN-1:0] periph_in_o,
  // interrupt and wake routing
  output logic external_interrupt_one_o,
  output logic external_interrupt_two_o,
  output logic external_nonmaskable_interrupt_o,
  output logic low_power_mode_wake_o
);

  gmx_state_type s_r;
  gmx_state_type s_nxt;

  // replace one 16-bit lane of a 32-bit register
  function automatic logic [31:0] lane(input logic [31:0] old,
                                       input logic hi,
                                       input logic [15:0] d);
    lane = hi ? {d, old[15:0]} : {old[31:16], d};
  endfunction

  // one 16-bit write; wide accesses call this for both halves
  function automatic gmx_state_type wr_half(input gmx_state_type st,
                                            input logic [15:0] wa,
                                            input logic [15:0] d,
                                            input logic prot);
    gmx_state_type n;
    logic [15:0] base;
    logic hi;
    logic [31:0] m;
    n = st;
    base = {wa[15:1], 1'b0};
    hi = wa[0];
    m = lane(GMX_RST_W32, hi, d);
    if (prot) begin
      unique case (base)
        GMX_OFS_CTRL_A: n.ctrl_a = lane(st.ctrl_a, hi, d);
        GMX_OFS_QSEL_A_LO: n.qsel[31:0] = lane(st.qsel[31:0], hi, d);
        GMX_OFS_QSEL_A_HI: n.qsel[63:32] = lane(st.qsel[63:32], hi, d);
        GMX_OFS_MUX_A_LO: n.mux[31:0] = lane(st.mux[31:0], hi, d);
        GMX_OFS_MUX_A_HI: n.mux[63:32] = lane(st.mux[63:32], hi, d);
        GMX_OFS_DIR_A: n.dir[31:0] = lane(st.dir[31:0], hi, d);
        GMX_OFS_PUD_A: n.pud[31:0] = lane(st.pud[31:0], hi, d);
        GMX_OFS_CTRL_B: begin
          if (!hi) begin
            n.ctrl_b = d[7:0];
          end
        end
        GMX_OFS_QSEL_B_LO: begin
          if (!hi) begin
            n.qsel[71:64] = d[7:0];
          end
        end
        GMX_OFS_MUX_B_LO: begin
          if (!hi) begin
            n.mux[71:64] = d[7:0];
          end
        end
        GMX_OFS_DIR_B: begin
          if (!hi) begin
            n.dir[35:32] = d[3:0];
          end
        end
        GMX_OFS_PUD_B: begin
          if (!hi) begin
            n.pud[35:32] = d[3:0];
          end
        end
        default: ;
      endcase
      unique case (wa)
        GMX_OFS_EXTERNAL_INTERRUPT_ONE_SEL: n.external_interrupt_one_sel = d[GMX_SEL_W-1:0];
        GMX_OFS_EXTERNAL_INTERRUPT_TWO_SEL: n.external_interrupt_two_sel = d[GMX_SEL_W-1:0];
        GMX_OFS_NMI_SEL: n.nmi_sel = d[GMX_SEL_W-1:0];
        default: ;
      endcase
      if (base == GMX_OFS_WAKE_SEL) begin
        n.wake_sel = lane(st.wake_sel, hi, d);
      end
    end
    // data group needs no protect enable
    unique case (base)
      GMX_OFS_DAT_A: n.dat[31:0] = lane(st.dat[31:0], hi, d);
      GMX_OFS_SET_A: n.dat[31:0] = st.dat[31:0] | m;
      GMX_OFS_CLR_A: n.dat[31:0] = st.dat[31:0] & ~m;
      GMX_OFS_TGL_A: n.dat[31:0] = st.dat[31:0] ^ m;
      GMX_OFS_DAT_B: begin
        // only the low word holds port B pins; the high word is reserved
        if (!hi) begin
          n.dat[35:32] = d[3:0];
        end
      end
      GMX_OFS_SET_B: n.dat[35:32] = st.dat[35:32] | m[3:0];
      GMX_OFS_CLR_B: n.dat[35:32] = st.dat[35:32] & ~m[3:0];
      GMX_OFS_TGL_B: n.dat[35:32] = st.dat[35:32] ^ m[3:0];
      default: ;
    endcase
    wr_half = n;
  endfunction

  // one 16-bit read; reserved and write-only words read as zero
  function automatic logic [15:0] rd_half(input gmx_state_type st,
                                          input logic [15:0] wa);
    logic [31:0] w;
    logic [15:0] base;
    w = GMX_RST_W32;
    base = {wa[15:1], 1'b0};
    unique case (base)
      GMX_OFS_CTRL_A: w = st.ctrl_a;
      GMX_OFS_QSEL_A_LO: w = st.qsel[31:0];
      GMX_OFS_QSEL_A_HI: w = st.qsel[63:32];
      GMX_OFS_MUX_A_LO: w = st.mux[31:0];
      GMX_OFS_MUX_A_HI: w = st.mux[63:32];
      GMX_OFS_DIR_A: w = st.dir[31:0];
      GMX_OFS_PUD_A: w = st.pud[31:0];
      GMX_OFS_CTRL_B: w = {24'h00_0000, st.ctrl_b};
      GMX_OFS_QSEL_B_LO: w = {24'h00_0000, st.qsel[71:64]};
      GMX_OFS_MUX_B_LO: w = {24'h00_0000, st.mux[71:64]};
      GMX_OFS_DIR_B: w = {28'h000_0000, st.dir[35:32]};
      GMX_OFS_PUD_B: w = {28'h000_0000, st.pud[35:32]};
      GMX_OFS_DAT_A: w = st.qual[31:0];
      GMX_OFS_DAT_B: w = {28'h000_0000, st.qual[35:32]};
      GMX_OFS_EXTERNAL_INTERRUPT_ONE_SEL: w = {11'h000, st.external_interrupt_two_sel, 11'h000, st.external_interrupt_one_sel};
      GMX_OFS_NMI_SEL: w = {27'h000_0000, st.nmi_sel};
      GMX_OFS_WAKE_SEL: w = st.wake_sel;
      default: w = GMX_RST_W32;
    endcase
    rd_half = wa[0] ? w[31:16] : w[15:0];
  endfunction

  always_comb begin
    logic [15:0] ea;
    logic [GMX_NGRP-1:0] tick;
    logic [7:0] period;
    logic [GMX_QHIST-1:0] h;
    logic [1:0] qs;
    int g;
    s_nxt = s_r;
    ea = {bus_req_i.addr[15:1], 1'b0};
    tick = '0;
    period = 8'h00;
    h = '0;
    qs = GMX_Q_SYNC;
    g = 0;

    // two-stage synchroniser on every pad
    s_nxt.sync1 = pad_in_i;
    s_nxt.sync2 = s_r.sync1;

    // sampling period per group of eight pins (four on port B) is twice the control byte, one cycle when the byte is zero
    for (int k = 0; k < GMX_NGRP; k++) begin
      period = (k < GMX_NGRP - 1) ? s_r.ctrl_a[8*k +: 8] : s_r.ctrl_b;
      tick[k] = (s_r.cnt[k] == '0);
      if (tick[k]) begin
        s_nxt.cnt[k] = (period == 8'h00) ? '0 : ({period, 1'b0} - 9'h001);
      end else begin
        s_nxt.cnt[k] = s_r.cnt[k] - 9'h001;
      end
    end

    // qualification: in the 3- and 6-sample modes a new level is taken only once it has held steady
    for (int i = 0; i < GMX_NPIN; i++) begin
      g = (i < GMX_NPIN_A) ? (i / GMX_GRP_PINS) : (GMX_NGRP - 1);
      qs = s_r.qsel[2*i +: 2];
      h = s_r.hist[i];
      if (tick[g]) begin
        h = {s_r.hist[i][GMX_QHIST-2:0], s_r.sync2[i]};
      end
      s_nxt.hist[i] = h;
      unique case (qs)
        GMX_Q_3SMP: begin
          if (h[2:0] == 3'h7 || h[2:0] == 3'h0) begin
            s_nxt.qual[i] = h[0];
          end
        end
        GMX_Q_6SMP: begin
          if (h == 6'h3F || h == 6'h00) begin
            s_nxt.qual[i] = h[0];
          end
        end
        GMX_Q_SYNC, GMX_Q_PASS: s_nxt.qual[i] = s_r.sync2[i];
      endcase
    end

    // register writes, low half first for wide accesses
    if (bus_req_i.wr) begin
      if (bus_req_i.wide) begin
        s_nxt = wr_half(s_nxt, ea, bus_req_i.wdata[15:0],
                        protected_write_enable_i);
        s_nxt = wr_half(s_nxt, ea | 16'h0001, bus_req_i.wdata[31:16],
                        protected_write_enable_i);
      end else begin
        s_nxt = wr_half(s_nxt, bus_req_i.addr, bus_req_i.wdata[15:0],
                        protected_write_enable_i);
      end
    end

    // reads answer one cycle later
    s_nxt.rvalid = bus_req_i.rd;
    if (bus_req_i.rd) begin
      if (bus_req_i.wide) begin
        s_nxt.rdata = {rd_half(s_r, ea | 16'h0001), rd_half(s_r, ea)};
      end else begin
        s_nxt.rdata = {16'h0000, rd_half(s_r, bus_req_i.addr)};
      end
    end

    // interrupt and wake sources come from qualified port A levels
    s_nxt.irq_lvl[0] = s_r.qual[s_r.external_interrupt_one_sel];
    s_nxt.irq_lvl[1] = s_r.qual[s_r.external_interrupt_two_sel];
    s_nxt.irq_lvl[2] = s_r.qual[s_r.nmi_sel];
    s_nxt.wake = |(s_r.wake_sel & s_r.qual[31:0]);
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s_r.sync1 <= GMX_RST_PIN;
      s_r.sync2 <= GMX_RST_PIN;
      s_r.hist <= '0;
      s_r.qual <= GMX_RST_PIN;
      s_r.cnt <= '0;
      s_r.ctrl_a <= GMX_RST_W32;
      s_r.ctrl_b <= GMX_RST_CTRL_B;
      s_r.qsel <= GMX_RST_FLD;
      s_r.mux <= GMX_RST_FLD;
      s_r.dir <= GMX_RST_PIN;
      s_r.pud <= GMX_RST_PIN;
      s_r.dat <= GMX_RST_PIN;
      s_r.external_interrupt_one_sel <= GMX_RST_SEL;
      s_r.external_interrupt_two_sel <= GMX_RST_SEL;
      s_r.nmi_sel <= GMX_RST_SEL;
      s_r.wake_sel <= GMX_RST_W32;
      s_r.irq_lvl <= 3'h0;
      s_r.wake <= 1'b0;
      s_r.rdata <= GMX_RST_W32;
      s_r.rvalid <= 1'b0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // pin output mux; the peripheral path stays combinational so that a
  // peripheral sees no extra latency on its pin
  always_comb begin
    logic [1:0] sel;
    sel = GMX_MUX_IO;
    for (int i = 0; i < GMX_NPIN; i++) begin
      sel = s_r.mux[2*i +: 2];
      if (sel == GMX_MUX_IO) begin
        pad_o.level[i] = s_r.dat[i];
        pad_o.drive[i] = s_r.dir[i];
      end else begin
        pad_o.level[i] = periph_out_i[sel - 2'h1][i];
        pad_o.drive[i] = periph_oe_i[sel - 2'h1][i];
      end
    end
    pad_o.pull_en = ~s_r.pud;
  end

  assign periph_in_o = s_r.qual;
  assign bus_rdata_o = s_r.rdata;
  assign bus_rvalid_o = s_r.rvalid;
  assign external_interrupt_one_o = s_r.irq_lvl[0];
  assign external_interrupt_two_o = s_r.irq_lvl[1];
  assign external_nonmaskable_interrupt_o = s_r.irq_lvl[2];
  assign low_power_mode_wake_o = s_r.wake;

endmodule // gmx_port

// *** tb/gmx_pad_model.sv ***
/*
  Board-side model of the pads of gmx_port.
  Assumes a released pin reads the pull-up when enabled, else the board.
*/
module gmx_pad_model
  import gmx_pkg::*;
(
  // pad side of the block
  input wire gmx_pad_type pad_i,
  // board drive seen on released, unpulled pins
  input wire logic [GMX_NPIN-1:0] ext_i,
  output logic [GMX_NPIN-1:0] pad_in_o
);
  always_comb begin
    pad_in_o = (pad_i.drive & pad_i.level)
      | (~pad_i.drive & pad_i.pull_en)
      | (~pad_i.drive & ~pad_i.pull_en & ext_i);
  end
endmodule // gmx_pad_model

// *** tb/gmx_port_props.sv ***
/*
  Port-level checker for gmx_port, bound to every instance.
  Assumes the single core clock and the active-low asynchronous reset.
*/
module gmx_port_props
  import gmx_pkg::*;
(
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rstn_i,
  // register port
  input wire gmx_bus_req_type bus_req_i,
  input wire logic protected_write_enable_i,
  input wire logic [31:0] bus_rdata_o,
  input wire logic bus_rvalid_o,
  // pins and routing
  input wire gmx_pad_type pad_o,
  input wire logic [GMX_NSRC-1:0][GMX_NPIN-1:0] periph_oe_i,
  input wire logic [GMX_NPIN-1:0] periph_in_o,
  input wire logic external_interrupt_one_o,
  input wire logic low_power_mode_wake_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);

  property p_read_ans;
    bus_req_i.rd |=> bus_rvalid_o;
  endproperty
  a_read_ans: assert property (p_read_ans)
    else $error("read not answered next cycle");
  property p_no_ans;
    !bus_req_i.rd |=> !bus_rvalid_o;
  endproperty
  a_no_ans: assert property (p_no_ans)
    else $error("answer without read");
  property p_narrow;
    bus_req_i.rd && !bus_req_i.wide |=> bus_rdata_o[31:16] == 16'h0;
  endproperty
  a_narrow: assert property (p_narrow)
    else $error("narrow read has upper half set");
  property p_hold;
    !bus_req_i.rd |=> $stable(bus_rdata_o);
  endproperty
  a_hold: assert property (p_hold)
    else $error("read data moved without read");
  property p_rsvd;
    bus_req_i.rd && (bus_req_i.addr inside
      {16'h6F98, 16'h6F99, [16'h6FA0:16'h6FBF]}) |=> bus_rdata_o == 32'h0;
  endproperty
  a_rsvd: assert property (p_rsvd)
    else $error("reserved word read nonzero");
  property p_portb;
    bus_req_i.rd && bus_req_i.addr == GMX_OFS_DIR_B
      |=> bus_rdata_o[31:4] == 28'h0;
  endproperty
  a_portb: assert property (p_portb)
    else $error("port B reserved bits read nonzero");
  property p_pull;
    $changed(pad_o.pull_en)
      |-> $past(bus_req_i.wr && protected_write_enable_i);
  endproperty
  a_pull: assert property (p_pull)
    else $error("pull-up changed without enabled write");
  property p_drive;
    $changed(pad_o.drive) |-> $past(bus_req_i.wr) || $changed(periph_oe_i);
  endproperty
  a_drive: assert property (p_drive)
    else $error("drive changed without cause");
  property p_irq;
    external_interrupt_one_o |-> $past(|periph_in_o[31:0]);
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt high with no port A pin high");
  property p_wake;
    $rose(low_power_mode_wake_o) |-> $past(|periph_in_o[31:0]);
  endproperty
  a_wake: assert property (p_wake)
    else $error("wake rose with no port A pin high");
endmodule // gmx_port_props

bind gmx_port gmx_port_props u_props (
  .core_clk_i(core_clk_i),
  .rstn_i(rstn_i),
  .bus_req_i(bus_req_i),
  .protected_write_enable_i(protected_write_enable_i),
  .bus_rdata_o(bus_rdata_o),
  .bus_rvalid_o(bus_rvalid_o),
  .pad_o(pad_o),
  .periph_oe_i(periph_oe_i),
  .periph_in_o(periph_in_o),
  .external_interrupt_one_o(external_interrupt_one_o),
  .low_power_mode_wake_o(low_power_mode_wake_o)
);

// *** tb/gmx_port_tb_top.sv ***
/*
  Self-checking bench for gmx_port with the pad model on its pins.
  Assumes the block answers reads one cycle after the read strobe.
*/
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_fail++; \
  $display("unexpected at %0t: got %h exp %h", $time, g, e); end end

module gmx_port_tb_top
  import gmx_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic pwe = 1'b0;
  gmx_bus_req_type req = '0;
  gmx_pad_type pad;
  logic [GMX_NPIN-1:0] pad_in, pin_q;
  logic [GMX_NPIN-1:0] ext = '0;
  logic [GMX_NSRC-1:0][GMX_NPIN-1:0] po = '0;
  logic [GMX_NSRC-1:0][GMX_NPIN-1:0] poe = '0;
  logic [31:0] rdata;
  logic rvalid, irq1, irq2, nmi, wake;
  int n_fail = 0;
  int tests_run = 0;

  gmx_port u_dut (.core_clk_i(clk), .rstn_i(rstn), .bus_req_i(req),
    .protected_write_enable_i(pwe), .bus_rdata_o(rdata),
    .bus_rvalid_o(rvalid), .pad_in_i(pad_in), .pad_o(pad),
    .periph_out_i(po), .periph_oe_i(poe), .periph_in_o(pin_q),
    .external_interrupt_one_o(irq1), .external_interrupt_two_o(irq2),
    .external_nonmaskable_interrupt_o(nmi),
    .low_power_mode_wake_o(wake));
  gmx_pad_model u_pads (.pad_i(pad), .ext_i(ext), .pad_in_o(pad_in));

  initial begin
    forever #2 clk = ~clk;
  end

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic rst;
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    #1;
  endtask

  task automatic wr(input logic [15:0] a, input logic [31:0] v,
                    input logic w, input logic p);
    @(posedge clk);
    req <= '{1'b1, 1'b0, w, a, v};
    pwe <= p;
    @(posedge clk);
    req.wr <= 1'b0;
    #1;
  endtask

  task automatic rc(input logic [15:0] a, input logic w,
                    input logic [31:0] e);
    @(posedge clk);
    req <= '{1'b0, 1'b1, w, a, 32'h0};
    @(posedge clk);
    req.rd <= 1'b0;
    #1;
    `CHK(rvalid, 1'b1)
    `CHK(rdata, e)
  endtask

  task automatic t_reset;
    rst();
    `CHK(pad.pull_en, {GMX_NPIN{1'b1}})
    `CHK(pad.drive, GMX_RST_PIN)
    rc(GMX_OFS_MUX_A_LO, 1'b1, 32'h0);
  endtask

  task automatic t_prot;
    rst();
    wr(GMX_OFS_DIR_B, 32'hF, 1'b1, 1'b0);
    rc(GMX_OFS_DIR_B, 1'b1, 32'h0);
    wr(GMX_OFS_DIR_B, 32'hFFFF_FFFF, 1'b1, 1'b1);
    rc(GMX_OFS_DIR_B, 1'b1, 32'hF);
    wr(16'h6F8B, 32'hABCD, 1'b0, 1'b1);
    rc(GMX_OFS_DIR_A, 1'b1, 32'hABCD_0000);
    rc(16'h6F8B, 1'b0, 32'hABCD);
    wr(GMX_OFS_QSEL_A_HI, 32'h8000_0001, 1'b1, 1'b1);
    rc(GMX_OFS_QSEL_A_HI, 1'b1, 32'h8000_0001);
    wr(GMX_OFS_QSEL_B_HI, 32'h1, 1'b1, 1'b1);
    rc(GMX_OFS_QSEL_B_HI, 1'b1, 32'h0);
    wr(GMX_OFS_EXTERNAL_INTERRUPT_ONE_SEL, 32'h5, 1'b0, 1'b0);
    rc(GMX_OFS_EXTERNAL_INTERRUPT_ONE_SEL, 1'b0, 32'h0);
    rc(GMX_OFS_MUX_B_HI, 1'b1, 32'h0);
    wr(GMX_OFS_CTRL_B, 32'h12, 1'b1, 1'b0);
    rc(GMX_OFS_CTRL_B, 1'b1, 32'h0);
    wr(GMX_OFS_CTRL_A, 32'h0102_0304, 1'b1, 1'b1);
    rc(GMX_OFS_CTRL_A, 1'b1, 32'h0102_0304);
  endtask

  task automatic t_data;
    rst();
    wr(GMX_OFS_DAT_A, 32'h1234, 1'b1, 1'b0);
    `CHK(pad.level[31:0], 32'h1234)
    repeat (6) @(posedge clk);
    rc(GMX_OFS_DAT_A, 1'b1, 32'hFFFF_FFFF);
    wr(GMX_OFS_DIR_A, 32'hFFFF_FFFF, 1'b1, 1'b1);
    wr(GMX_OFS_SET_A, 32'hF, 1'b1, 1'b0);
    `CHK(pad.level[31:0], 32'h123F)
    wr(GMX_OFS_CLR_A, 32'h30, 1'b1, 1'b0);
    `CHK(pad.level[31:0], 32'h120F)
    wr(GMX_OFS_TGL_A, 32'hFFFF_0000, 1'b1, 1'b0);
    `CHK(pad.level[31:0], 32'hFFFF_120F)
    wr(16'h6FC7, 32'h1, 1'b0, 1'b0);
    `CHK(pad.level[31:0], 32'hFFFE_120F)
    repeat (6) @(posedge clk);
    rc(GMX_OFS_DAT_A, 1'b1, 32'hFFFE_120F);
    wr(GMX_OFS_DIR_B, 32'hF, 1'b1, 1'b1);
    wr(GMX_OFS_DAT_B, 32'hFFFF_FFF5, 1'b1, 1'b0);
    `CHK(pad.level[35:32], 4'h5)
    wr(GMX_OFS_TGL_B, 32'h3, 1'b1, 1'b0);
    `CHK(pad.level[35:32], 4'h6)
    repeat (6) @(posedge clk);
    rc(GMX_OFS_DAT_B, 1'b1, 32'h6);
  endtask

  task automatic t_mux;
    rst();
    @(posedge clk);
    poe <= '1;
    po[0] <= 36'h1;
    po[1] <= 36'h2;
    po[2] <= 36'h3;
    for (int c = 1; c < 4; c++) begin
      wr(GMX_OFS_MUX_A_LO, 32'(c * 5), 1'b0, 1'b1);
      `CHK(pad.level[1:0], 2'(c))
      `CHK(pad.drive[1:0], 2'h3)
    end
    wr(GMX_OFS_MUX_A_LO, 32'h0, 1'b0, 1'b0);
    `CHK(pad.level[1:0], 2'h3)
    wr(GMX_OFS_MUX_A_LO, 32'h0, 1'b0, 1'b1);
    `CHK(pad.drive[1:0], 2'h0)
  endtask

  task automatic t_irq;
    rst();
    wr(GMX_OFS_PUD_A, 32'hFFFF_FFFF, 1'b1, 1'b1);
    wr(GMX_OFS_EXTERNAL_INTERRUPT_ONE_SEL, 32'h5, 1'b0, 1'b1);
    wr(GMX_OFS_NMI_SEL, 32'h5, 1'b0, 1'b1);
    wr(GMX_OFS_EXTERNAL_INTERRUPT_TWO_SEL, 32'h3, 1'b0, 1'b1);
    wr(GMX_OFS_WAKE_SEL, 32'h20, 1'b1, 1'b1);
    ext <= 36'h20;
    repeat (6) @(posedge clk);
    #1;
    `CHK({irq1, irq2, nmi, wake}, 4'b1011)
    `CHK(pin_q[5], 1'b1)
    ext <= 36'h0;
    repeat (6) @(posedge clk);
    #1;
    `CHK({irq1, nmi, wake}, 3'b000)
    wr(GMX_OFS_WAKE_SEL, 32'h8, 1'b1, 1'b0);
    ext <= 36'h8;
    repeat (6) @(posedge clk);
    #1;
    `CHK({irq1, irq2, nmi, wake}, 4'b0100)
    rc(GMX_OFS_EXTERNAL_INTERRUPT_ONE_SEL, 1'b1, 32'h0003_0005);
    rc(GMX_OFS_WAKE_SEL, 1'b1, 32'h20);
  endtask

  // pin 0 six samples, pin 1 three samples, pin 2 code 3 (plain sync);
  // pins are held low long enough that no stale high sits in the history
  task automatic t_qual;
    rst();
    wr(GMX_OFS_PUD_A, 32'hFFFF_FFFF, 1'b1, 1'b1);
    repeat (4) @(posedge clk);
    wr(GMX_OFS_QSEL_A_LO, 32'h36, 1'b0, 1'b1);
    ext <= 36'h7;
    repeat (4) @(posedge clk);
    #1;
    `CHK(pin_q[2:0], 3'b100)
    repeat (2) @(posedge clk);
    #1;
    `CHK(pin_q[2:0], 3'b110)
    repeat (3) @(posedge clk);
    #1;
    `CHK(pin_q[2:0], 3'b111)
    ext <= 36'h0;
  endtask

  initial begin
    t_reset();
    t_prot();
    t_data();
    t_mux();
    t_qual();
    t_irq();
    print_verdict();
  end

  // the scenarios take under two hundred cycles; this bounds a hang
  initial begin
    repeat (5000) @(posedge clk);
    n_fail++;
    print_verdict();
  end
endmodule // gmx_port_tb_top
